/* File: lvl_ctrl.sv */
// Host sequencer for clock frequency change in power-down and for write leveling.
//
// Added by the designer: the APB register port and the register offsets.
module lvl_ctrl #(
  parameter int DLY_W  = 6,
  parameter int FSEL_W = 2,
  parameter int LANES  = 2
) (
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  output logic                   cke,
  output logic                   odt,
  output logic [3:0]             cmd_n,
  output logic [2:0]             ba,
  output logic [15:0]            addr,
  output logic [LANES-1:0]       dqs_o,
  output logic [LANES-1:0]       dqs_oe,
  output logic                   dq_oe,
  input  wire logic [8*LANES-1:0] dq_i,
  output logic [FSEL_W-1:0]      freq_sel,
  output logic                   freq_req,
  input  wire logic              freq_ack
);
  if (LANES < 1 || LANES > 2 || DLY_W < 2 || DLY_W > 8 || FSEL_W < 1 || FSEL_W > 8) begin : g_bad_param
    $error("lvl_ctrl: unsupported parameter value");
  end

  typedef enum logic [14:0] {
    S_IDLE  = 15'h0001, S_PD_IN = 15'h0002, S_SRE   = 15'h0004, S_FREQ  = 15'h0008,
    S_SRX   = 15'h0010, S_XP    = 15'h0020, S_DLLMR = 15'h0040, S_DLLK  = 15'h0080,
    S_WLMR  = 15'h0100, S_WLMOD = 15'h0200, S_DQSEN = 15'h0400, S_PULSE = 15'h0800,
    S_WLO   = 15'h1000, S_EVAL  = 15'h2000, S_WLEND = 15'h4000
  } state_type;

  state_type                 state_reg;
  logic [lvl_pkg::WAIT_W-1:0] wait_reg;
  logic [lvl_pkg::MR_W-1:0]  mr0_reg;
  logic [lvl_pkg::MR_W-1:0]  mr1_reg;
  logic [FSEL_W-1:0]         fsel_reg;
  logic                      wide_reg;
  logic                      go_freq_reg;
  logic                      go_lvl_reg;
  logic                      fdone_reg;
  logic                      ldone_reg;
  logic                      fail_reg;
  logic [1:0]                ack_sync_reg;
  logic [8*LANES-1:0]        dq_meta_reg;
  logic [8*LANES-1:0]        dq_sync_reg;
  logic [DLY_W-1:0]          dly_reg [LANES];
  logic [LANES-1:0]          prev_reg;
  logic [LANES-1:0]          lock_reg;
  logic [LANES-1:0]          start_reg;
  logic [LANES-1:0]          sdone_reg;
  logic [LANES-1:0]          lane_on;
  logic [LANES-1:0]          sdone;
  logic [LANES-1:0]          sdqs;
  logic                      apb_wr;
  logic                      apb_rd;

  // ****************************************************************************
  // Strobe generators, one per byte lane
  // ****************************************************************************
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    lvl_strobe_if #(.DLY_W(DLY_W)) sif ();
    assign sif.start = start_reg[l];
    assign sif.delay = dly_reg[l];
    assign sdone[l]  = sif.done;
    assign sdqs[l]   = sif.dqs;
    assign lane_on[l] = (l == 0) || wide_reg;
    lvl_strobe #(.DLY_W(DLY_W)) u_strobe (
      .core_clk (core_clk),
      .resetn   (resetn),
      .sif      (sif)
    );
  end

  function automatic logic [lvl_pkg::WAIT_W-1:0] wcnt(input int cyc);
    return lvl_pkg::WAIT_W'(cyc - 1);
  endfunction

  // ****************************************************************************
  // Pin synchronisers
  // ****************************************************************************
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ack_sync_reg <= 2'h0;
      dq_meta_reg  <= '0;
      dq_sync_reg  <= '0;
    end else begin
      ack_sync_reg <= {ack_sync_reg[0], freq_ack};
      dq_meta_reg  <= dq_i;
      dq_sync_reg  <= dq_meta_reg;
    end
  end

  // ****************************************************************************
  // APB slave, one wait state so that every bus output is a register
  // ****************************************************************************
  assign apb_wr = psel && penable && pready && pwrite;
  assign apb_rd = psel && penable && !pready && !pwrite;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        case (paddr)
          lvl_pkg::ADDR_CTRL, lvl_pkg::ADDR_MR0, lvl_pkg::ADDR_MR1,
          lvl_pkg::ADDR_STATUS, lvl_pkg::ADDR_DELAY, lvl_pkg::ADDR_FSEL: pslverr <= 1'b0;
          default: pslverr <= 1'b1;
        endcase
      end
      if (apb_rd) begin
        case (paddr)
          lvl_pkg::ADDR_CTRL: prdata <= {29'h0, wide_reg, 2'h0};
          lvl_pkg::ADDR_STATUS: prdata <= 32'({lock_reg, fail_reg, ldone_reg, fdone_reg, state_reg != S_IDLE});
          lvl_pkg::ADDR_MR0: prdata <= {16'h0, mr0_reg};
          lvl_pkg::ADDR_MR1: prdata <= {16'h0, mr1_reg};
          lvl_pkg::ADDR_DELAY: prdata <= {16'h0, 8'(dly_reg[LANES-1]), 8'(dly_reg[0])};
          lvl_pkg::ADDR_FSEL: prdata <= 32'(fsel_reg);
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mr0_reg     <= lvl_pkg::MR0_RESET;
      mr1_reg     <= lvl_pkg::MR1_RESET;
      fsel_reg    <= '0;
      wide_reg    <= 1'b0;
      go_freq_reg <= 1'b0;
      go_lvl_reg  <= 1'b0;
    end else begin
      if (state_reg != S_IDLE) begin
        go_freq_reg <= 1'b0;
        go_lvl_reg  <= 1'b0;
      end
      if (apb_wr) begin
        case (paddr)
          lvl_pkg::ADDR_CTRL: begin
            go_freq_reg <= pwdata[lvl_pkg::CTRL_FREQ_BIT];
            go_lvl_reg  <= pwdata[lvl_pkg::CTRL_LEVEL_BIT];
            wide_reg    <= pwdata[lvl_pkg::CTRL_WIDE_BIT] && (LANES == 2);
          end
          lvl_pkg::ADDR_MR0: mr0_reg <= pwdata[lvl_pkg::MR_W-1:0];
          lvl_pkg::ADDR_MR1: mr1_reg <= pwdata[lvl_pkg::MR_W-1:0];
          lvl_pkg::ADDR_FSEL: fsel_reg <= pwdata[FSEL_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // ****************************************************************************
  // Sequencer
  // ****************************************************************************
  // A change is only ever requested from power-down, so the clock stays fixed in every other state.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_reg <= S_IDLE;
      wait_reg  <= '0;
      cke       <= 1'b1;
      odt       <= 1'b0;
      cmd_n     <= lvl_pkg::CMD_DES;
      ba        <= 3'h0;
      addr      <= 16'h0000;
      freq_req  <= 1'b0;
      freq_sel  <= '0;
      fdone_reg <= 1'b0;
      ldone_reg <= 1'b0;
      fail_reg  <= 1'b0;
      dqs_oe    <= '0;
      dq_oe     <= 1'b0;
      start_reg <= '0;
      sdone_reg <= '0;
    end else begin
      cmd_n     <= lvl_pkg::CMD_NOP;
      dq_oe     <= 1'b0;
      start_reg <= '0;
      sdone_reg <= sdone_reg | sdone;
      if (wait_reg != '0) begin
        wait_reg <= wait_reg - 1'b1;
      end
      case (state_reg)
        S_IDLE: begin
          if (go_freq_reg) begin
            odt       <= 1'b0;
            fdone_reg <= 1'b0;
            state_reg <= S_PD_IN;
          end else if (go_lvl_reg) begin
            ldone_reg <= 1'b0;
            fail_reg  <= 1'b0;
            state_reg <= S_WLMR;
          end
        end
        S_PD_IN: begin
          cke       <= 1'b0;
          wait_reg  <= wcnt(lvl_pkg::CKSRE_CYC);
          state_reg <= S_SRE;
        end
        S_SRE: if (wait_reg == '0) begin
          freq_sel  <= fsel_reg;
          freq_req  <= 1'b1;
          state_reg <= S_FREQ;
        end
        S_FREQ: if (ack_sync_reg[1]) begin
          freq_req  <= 1'b0;
          wait_reg  <= wcnt(lvl_pkg::CKSRX_CYC);
          state_reg <= S_SRX;
        end
        S_SRX: if (wait_reg == '0) begin
          cke       <= 1'b1;
          wait_reg  <= wcnt(lvl_pkg::XP_CYC);
          state_reg <= S_XP;
        end
        S_XP: if (wait_reg == '0) begin
          cmd_n     <= lvl_pkg::CMD_MRS;
          ba        <= lvl_pkg::BA_MR0;
          addr      <= mr0_reg | (16'h0001 << lvl_pkg::MR0_DLL_RST_BIT);
          wait_reg  <= wcnt(lvl_pkg::T_DLLK_CK);
          state_reg <= S_DLLK;
        end
        S_DLLK: if (wait_reg == '0) begin
          fdone_reg <= 1'b1;
          state_reg <= S_IDLE;
        end
        S_WLMR: begin
          cmd_n     <= lvl_pkg::CMD_MRS;
          ba        <= lvl_pkg::BA_MR1;
          addr      <= (mr1_reg | (16'h0001 << lvl_pkg::MR1_LEVEL_BIT))
                       & ~(16'h0001 << lvl_pkg::MR1_QOFF_BIT);
          wait_reg  <= wcnt(lvl_pkg::MOD_CYC);
          sdone_reg <= '0;
          state_reg <= S_WLMOD;
        end
        S_WLMOD: if (wait_reg == '0) begin
          odt       <= 1'b1;
          wait_reg  <= wcnt(lvl_pkg::T_DQSEN_CK);
          state_reg <= S_DQSEN;
        end
        S_DQSEN: if (wait_reg == '0) begin
          dqs_oe    <= lane_on;
          wait_reg  <= wcnt(lvl_pkg::T_WLMRD_CK);
          state_reg <= S_PULSE;
        end
        S_PULSE: if (wait_reg == '0) begin
          start_reg <= lane_on & ~lock_reg;
          sdone_reg <= ~(lane_on & ~lock_reg);
          state_reg <= S_WLO;
        end
        S_WLO: if (&sdone_reg) begin
          wait_reg  <= wcnt(lvl_pkg::WLO_CYC);
          state_reg <= S_EVAL;
        end
        S_EVAL: if (wait_reg == '0) begin
          if ((lock_reg | ~lane_on) == {LANES{1'b1}} || fail_reg) begin
            dqs_oe    <= '0;
            odt       <= 1'b0;
            wait_reg  <= wcnt(lvl_pkg::MOD_CYC);
            state_reg <= S_WLEND;
          end else begin
            wait_reg  <= wcnt(lvl_pkg::T_DQSH_CK + 1);
            state_reg <= S_PULSE;
          end
        end
        S_WLEND: if (wait_reg == '0) begin
          cmd_n     <= lvl_pkg::CMD_MRS;
          ba        <= lvl_pkg::BA_MR1;
          addr      <= mr1_reg & ~(16'h0001 << lvl_pkg::MR1_LEVEL_BIT);
          ldone_reg <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
      if (state_reg == S_EVAL && wait_reg == '0) begin
        for (int l = 0; l < LANES; l++) begin
          if (lane_on[l] && !lock_reg[l] && &dly_reg[l] && !(!prev_reg[l] && dq_sync_reg[8*l])) begin
            fail_reg <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************************************************
  // Per-lane delay search
  // ****************************************************************************
  // The last sample starts at one, so a lane locks only on a genuine low-to-high step.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      prev_reg <= '1;
      lock_reg <= '0;
      for (int l = 0; l < LANES; l++) begin
        dly_reg[l] <= '0;
      end
    end else if (state_reg == S_WLMR) begin
      prev_reg <= '1;
      lock_reg <= '0;
      for (int l = 0; l < LANES; l++) begin
        dly_reg[l] <= '0;
      end
    end else if (state_reg == S_EVAL && wait_reg == '0) begin
      for (int l = 0; l < LANES; l++) begin
        if (lane_on[l] && !lock_reg[l]) begin
          prev_reg[l] <= dq_sync_reg[8*l];
          if (!prev_reg[l] && dq_sync_reg[8*l]) begin
            lock_reg[l] <= 1'b1;
          end else if (!(&dly_reg[l])) begin
            dly_reg[l] <= dly_reg[l] + 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      dqs_o <= '0;
    end else begin
      dqs_o <= sdqs;
    end
  end
endmodule

/* File: lvl_pkg.sv */
// Constants, register map and timing counts for the frequency change and write leveling controller.
// ****************************************************************************
// ****************************************************************************
package lvl_pkg;
  // ****************************************************************************
  // Register map
  // ****************************************************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MR0    = 8'h08;
  localparam logic [7:0] ADDR_MR1    = 8'h0C;
  localparam logic [7:0] ADDR_DELAY  = 8'h10;
  localparam logic [7:0] ADDR_FSEL   = 8'h14;
  localparam int CTRL_FREQ_BIT  = 0;
  localparam int CTRL_LEVEL_BIT = 1;
  localparam int CTRL_WIDE_BIT  = 2;
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_FDONE_BIT   = 1;
  localparam int ST_LDONE_BIT   = 2;
  localparam int ST_FAIL_BIT    = 3;
  localparam int ST_LOCK_BIT    = 4;
  localparam int DELAY_LANE1_LSB = 8;
  localparam int MR_W           = 16;
  localparam logic [MR_W-1:0] MR0_RESET = 16'h0000;
  localparam logic [MR_W-1:0] MR1_RESET = 16'h0000;
  localparam int MR0_DLL_RST_BIT = 8;
  localparam int MR1_LEVEL_BIT   = 7;
  localparam int MR1_QOFF_BIT    = 12;
  localparam logic [2:0] BA_MR0 = 3'h0;
  localparam logic [2:0] BA_MR1 = 3'h1;
  // ****************************************************************************
  // Commands as {cs_n, ras_n, cas_n, we_n}
  // ****************************************************************************
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_DES = 4'hF;
  localparam logic [3:0] CMD_MRS = 4'h0;
  // ****************************************************************************
  // Timing, times in ns or in clocks, counts derived at 50 MHz
  // ****************************************************************************
  localparam int CLK_MHZ      = 50;
  localparam int T_CKSRE_NS   = 10;
  localparam int T_CKSRX_NS   = 10;
  localparam int T_XP_NS      = 24;
  localparam int T_MOD_NS     = 15;
  localparam int T_WLO_NS     = 9;
  localparam int T_MRD_CK     = 4;
  localparam int T_DLLK_CK    = 512;
  localparam int T_WLMRD_CK   = 40;
  localparam int T_DQSEN_CK   = 25;
  localparam int T_DQSH_CK    = 1;
  localparam int SYNC_CK      = 2;
  localparam int WAIT_W       = 10;
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int CKSRE_CYC = ceil_cyc(T_CKSRE_NS);
  localparam int CKSRX_CYC = ceil_cyc(T_CKSRX_NS);
  localparam int XP_CYC    = ceil_cyc(T_XP_NS);
  localparam int MOD_CYC   = ceil_cyc(T_MOD_NS);
  localparam int WLO_CYC   = ceil_cyc(T_WLO_NS) + SYNC_CK;
endpackage

/* File: lvl_strobe_if.sv */
// Strobe pulse request and result between the sequencer and one lane generator.
interface lvl_strobe_if #(parameter int DLY_W = 6);
  logic             start;
  logic [DLY_W-1:0] delay;
  logic             dqs;
  logic             done;
  modport ctrl   (output start, output delay, input dqs, input done);
  modport strobe (input start, input delay, output dqs, output done);
endinterface

/* File: lvl_strobe.sv */
// One-lane strobe generator: a single delayed rising pulse per request.
module lvl_strobe #(
  parameter int DLY_W = 6
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  lvl_strobe_if.strobe     sif
);
  logic [DLY_W-1:0] cnt_reg;
  logic [1:0]       hi_reg;
  logic             run_reg;

  // ****************************************************************************
  // Delay then pulse
  // ****************************************************************************
  // The rising edge lands delay plus one cycles after start is sampled; that is the adjustable strobe delay.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cnt_reg  <= '0;
      hi_reg   <= 2'h0;
      run_reg  <= 1'b0;
      sif.dqs  <= 1'b0;
      sif.done <= 1'b0;
    end else begin
      sif.done <= 1'b0;
      if (sif.start && !run_reg) begin
        run_reg <= 1'b1;
        cnt_reg <= sif.delay;
        hi_reg  <= 2'(lvl_pkg::T_DQSH_CK);
      end else if (run_reg) begin
        if (cnt_reg != '0) begin
          cnt_reg <= cnt_reg - 1'b1;
        end else if (!sif.dqs) begin
          sif.dqs <= 1'b1;
        end else if (hi_reg > 2'h1) begin
          hi_reg <= hi_reg - 2'h1;
        end else begin
          sif.dqs  <= 1'b0;
          sif.done <= 1'b1;
          run_reg  <= 1'b0;
        end
      end
    end
  end
endmodule

/* File: lvl_ctrl_asserts.sv */
// Port-level assertions for the frequency change and write leveling sequencer.
module lvl_ctrl_asserts #(
  parameter int LANES = 2
) (
  input wire logic             core_clk,
  input wire logic             resetn,
  input wire logic             cke,
  input wire logic             odt,
  input wire logic [3:0]       cmd_n,
  input wire logic [2:0]       ba,
  input wire logic [15:0]      addr,
  input wire logic [LANES-1:0] dqs_o,
  input wire logic [LANES-1:0] dqs_oe,
  input wire logic             dq_oe,
  input wire logic             freq_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************************
  // Helpers and properties
  // ****************************************************************************
  logic [9:0] lock_cnt_reg;
  wire        mrs = (cmd_n == lvl_pkg::CMD_MRS);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // The lock window is far longer than any repetition, so it is counted here.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      lock_cnt_reg <= 10'h000;
    end else if (mrs && ba == lvl_pkg::BA_MR0 && addr[lvl_pkg::MR0_DLL_RST_BIT]) begin
      lock_cnt_reg <= 10'h200;
    end else if (lock_cnt_reg != 10'h000) begin
      lock_cnt_reg <= lock_cnt_reg - 10'h001;
    end
  end
  property p_dq_free; dq_oe == 1'b0; endproperty
  property p_cmd_lvl; odt |-> (cmd_n == lvl_pkg::CMD_NOP || cmd_n == lvl_pkg::CMD_DES); endproperty
  property p_req_cke; freq_req |-> !cke && !odt; endproperty
  property p_req_wait; $rose(freq_req) |-> $past(cke) == 1'b0; endproperty
  property p_cke_ret; $fell(freq_req) |-> !cke ##[1:4] cke; endproperty
  property p_dll_rst;
    $rose(cke) |-> !mrs [*2] ##[1:4] (mrs && ba == lvl_pkg::BA_MR0 && addr[8]);
  endproperty
  property p_lock_odt; lock_cnt_reg != 10'h000 |-> !odt; endproperty
  property p_odt_mod; $rose(odt) |-> $past(mrs) && $past(ba) == lvl_pkg::BA_MR1 && !mrs; endproperty
  property p_lvl_qon; mrs && ba == lvl_pkg::BA_MR1 && addr[7] |-> !addr[12] && !odt; endproperty
  property p_dqs_odt; |dqs_oe |-> odt; endproperty
  property p_pulse; $rose(dqs_o[0]) |-> dqs_oe[0] ##1 !dqs_o[0]; endproperty
  a_dq_free: assert property (p_dq_free) else $error("dq driven");
  a_cmd_lvl: assert property (p_cmd_lvl) else $error("command while odt high");
  a_req_cke: assert property (p_req_cke) else $error("clock change with cke or odt high");
  a_req_wait: assert property (p_req_wait) else $error("clock change too soon");
  a_cke_ret: assert property (p_cke_ret) else $error("cke exit timing");
  a_dll_rst: assert property (p_dll_rst) else $error("no dll reset after exit");
  a_lock_odt: assert property (p_lock_odt) else $error("odt during dll lock");
  a_odt_mod: assert property (p_odt_mod) else $error("odt raised before mode update delay");
  a_lvl_qon: assert property (p_lvl_qon) else $error("leveling entry setup");
  a_dqs_odt: assert property (p_dqs_odt) else $error("strobe driven without odt");
  a_pulse: assert property (p_pulse) else $error("strobe pulse shape");
  c_freq: cover property ($rose(freq_req));
  c_lvl: cover property ($rose(dqs_oe[0]));
  c_exit: cover property (mrs && ba == lvl_pkg::BA_MR1 && !addr[7]);
endmodule

bind lvl_ctrl lvl_ctrl_asserts #(.LANES(LANES)) asserts_inst (
  .core_clk(core_clk), .resetn(resetn), .cke(cke), .odt(odt), .cmd_n(cmd_n), .ba(ba),
  .addr(addr), .dqs_o(dqs_o), .dqs_oe(dqs_oe), .dq_oe(dq_oe), .freq_req(freq_req));

/* File: ddr_dev_model.sv */
// Behavioural memory device answering mode writes and write leveling strobes.
module ddr_dev_model (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        cke,
  input  wire logic        odt,
  input  wire logic [3:0]  cmd_n,
  input  wire logic [2:0]  ba,
  input  wire logic [15:0] addr,
  input  wire logic [1:0]  dqs_o,
  input  wire logic [1:0]  dqs_oe,
  input  wire logic        stuck,
  output logic      [15:0] dq,
  output logic             err_flag,
  output logic      [3:0]  samp_hist,
  output logic      [15:0] mr0_seen,
  output logic      [15:0] mr1_seen,
  output logic      [7:0]  dll_resets
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************************
  // Mode registers, lock time and strobe capture
  // ****************************************************************************
  logic [9:0] lock_reg;
  logic [3:0] ck_div_reg;
  logic [1:0] dqs_prev_reg;
  logic [1:0] prime_reg;
  wire        wl_on    = mr1_seen[7];
  wire        q_on     = ~mr1_seen[12];
  wire        dqs_term = wl_on & odt;
  wire        mrs      = cke && cmd_n == lvl_pkg::CMD_MRS;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mr0_seen   <= 16'h0000;
      mr1_seen   <= 16'h0000;
      lock_reg   <= 10'h000;
      dll_resets <= 8'h00;
      err_flag   <= 1'b0;
    end else begin
      if (mrs && ba == lvl_pkg::BA_MR1) begin
        mr1_seen <= addr;
      end
      if (mrs && ba == lvl_pkg::BA_MR0) begin
        mr0_seen <= addr;
        if (addr[lvl_pkg::MR0_DLL_RST_BIT]) begin
          lock_reg   <= 10'h200;
          dll_resets <= dll_resets + 8'h01;
        end
      end else if (lock_reg != 10'h000) begin
        lock_reg <= lock_reg - 10'h001;
      end
      if (lock_reg != 10'h000 && odt) begin
        err_flag <= 1'b1;
      end
      if (wl_on && cmd_n != lvl_pkg::CMD_NOP && cmd_n != lvl_pkg::CMD_DES && !mrs) begin
        err_flag <= 1'b1;
      end
    end
  end
  // The device clock runs at an eighth of the core rate so that strobe delay steps sweep its phase.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ck_div_reg   <= 4'h0;
      dqs_prev_reg <= 2'h0;
      prime_reg    <= 2'h0;
      samp_hist    <= 4'h0;
    end else begin
      ck_div_reg   <= ck_div_reg + 4'h1;
      dqs_prev_reg <= dqs_o;
      for (int i = 0; i < 2; i++) begin
        if (wl_on && q_on && dqs_oe[i] && dqs_o[i] && !dqs_prev_reg[i]) begin
          prime_reg[i]      <= ck_div_reg[2] & ~stuck;
          samp_hist[2*i+:2] <= {samp_hist[2*i], ck_div_reg[2] & ~stuck};
        end
      end
    end
  end
  // A released bus shows a toggling pattern, never the last value.
  always_comb begin
    if (wl_on && q_on) begin
      dq    = 16'h0000;
      dq[0] = prime_reg[0];
      dq[8] = prime_reg[1];
    end else begin
      dq = {16{ck_div_reg[0]}};
    end
  end
endmodule

/* File: testbench.sv */
// Self-checking bench for the frequency change and write leveling sequencer.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        resetn   = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h00000000;
  logic        freq_ack = 1'b0;
  logic [2:0]  ack_q    = 3'h0;
  logic        stuck    = 1'b0;
  logic        pready, pslverr, cke, odt, dq_oe, freq_req, err_flag;
  logic [31:0] prdata;
  logic [3:0]  cmd_n, samp_hist;
  logic [2:0]  ba;
  logic [15:0] addr, dq, mr0_seen, mr1_seen;
  logic [1:0]  dqs_o, dqs_oe, freq_sel;
  logic [7:0]  dll_resets;
  int          mismatches = 0;
  int          compares   = 0;
  always #10 core_clk = ~core_clk;
  // The clock generator acknowledges a change once the new rate is stable.
  always @(posedge core_clk) begin
    ack_q    <= {ack_q[1:0], freq_req};
    freq_ack <= ack_q[2];
  end
  lvl_ctrl #(.DLY_W(6), .FSEL_W(2), .LANES(2)) dut (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cke(cke), .odt(odt), .cmd_n(cmd_n), .ba(ba), .addr(addr), .dqs_o(dqs_o), .dqs_oe(dqs_oe),
    .dq_oe(dq_oe), .dq_i(dq), .freq_sel(freq_sel), .freq_req(freq_req), .freq_ack(freq_ack));
  ddr_dev_model dev (
    .core_clk(core_clk), .resetn(resetn), .cke(cke), .odt(odt), .cmd_n(cmd_n), .ba(ba),
    .addr(addr), .dqs_o(dqs_o), .dqs_oe(dqs_oe), .stuck(stuck), .dq(dq), .err_flag(err_flag),
    .samp_hist(samp_hist), .mr0_seen(mr0_seen), .mr1_seen(mr1_seen), .dll_resets(dll_resets));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      summarize();
    end
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic wait_bit(input int b, output logic [31:0] st);
    logic e;
    int   n;
    n = 0;
    do begin
      apb(1'b0, lvl_pkg::ADDR_STATUS, 32'h0, st, e);
      n++;
    end while (st[b] !== 1'b1 && n < 4000);
    if (st[b] !== 1'b1) begin
      mismatches++;
      summarize();
    end
  endtask
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    chk("cke in reset", 32'(cke), 32'h1);
    chk("odt in reset", 32'(odt), 32'h0);
    chk("cmd in reset", 32'(cmd_n), 32'(lvl_pkg::CMD_DES));
    resetn <= 1'b1;
    @(posedge core_clk);
    @(posedge core_clk);
    chk("cmd idle", 32'(cmd_n), 32'(lvl_pkg::CMD_NOP));
    apb(1'b0, lvl_pkg::ADDR_STATUS, 32'h0, r, e);
    chk("status reset", r, 32'h0);
    apb(1'b0, lvl_pkg::ADDR_MR1, 32'h0, r, e);
    chk("mr1 reset", r, 32'(lvl_pkg::MR1_RESET));
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk("unmapped error", 32'(e), 32'h1);
    chk("unmapped data", r, 32'h0);
  endtask
  task automatic t_freq();
    logic [31:0] st;
    wr(lvl_pkg::ADDR_FSEL, 32'h2);
    wr(lvl_pkg::ADDR_MR0, 32'h0A20);
    wr(lvl_pkg::ADDR_CTRL, 32'h1);
    wr(lvl_pkg::ADDR_CTRL, 32'h2);
    wait_bit(lvl_pkg::ST_FDONE_BIT, st);
    chk("flags after change", 32'(st[3:0]), 32'h2);
    chk("new clock select", 32'(freq_sel), 32'h2);
    chk("dll resets", 32'(dll_resets), 32'h1);
    chk("mr0 written", 32'(mr0_seen), 32'h0B20);
    chk("termination in lock", 32'(err_flag), 32'h0);
  endtask
  task automatic t_level(input logic wide, input logic stk);
    logic [31:0] st;
    stuck <= stk;
    wr(lvl_pkg::ADDR_MR1, 32'h1044);
    wr(lvl_pkg::ADDR_DELAY, 32'h0);
    wr(lvl_pkg::ADDR_CTRL, wide ? 32'h6 : 32'h2);
    wait_bit(lvl_pkg::ST_LDONE_BIT, st);
    chk("fail flag", 32'(st[lvl_pkg::ST_FAIL_BIT]), 32'(stk));
    chk("lane0 lock", 32'(st[lvl_pkg::ST_LOCK_BIT]), 32'(!stk));
    if (wide) begin
      chk("lane1 lock", 32'(st[lvl_pkg::ST_LOCK_BIT+1]), 32'h1);
      chk("lane1 samples", 32'(samp_hist[3:2]), 32'h1);
    end
    if (!stk) begin
      chk("lane0 samples", 32'(samp_hist[1:0]), 32'h1);
    end
    chk("leveling off", 32'(mr1_seen[7]), 32'h0);
    chk("commands in leveling", 32'(err_flag), 32'h0);
    chk("odt after exit", 32'(odt), 32'h0);
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    t_reset();
    t_freq();
    t_level(1'b1, 1'b0);
    t_level(1'b0, 1'b0);
    t_level(1'b0, 1'b1);
    summarize();
  end
endmodule
